// [verilog/ddrs_pkg.sv]
package ddrs_pkg;
  // ----------------------------------------------------------------
  // Clocking and organisation
  // ----------------------------------------------------------------
  localparam int SYS_PERIOD_NS = 10;
  localparam int DATA_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = DATA_W / LANE_W;
  localparam int ADDR_W = 4;
  localparam int BURST = 4;
  // ----------------------------------------------------------------
  // Device timing
  // ----------------------------------------------------------------
  localparam int CAL_INTERVAL = 1024;
  localparam int LOCK_CYCLES = 1024;
  localparam int STALL_NS = 30;
  localparam int K_HALF_NS = 60;
  // A stall is a gap longer than a nominal half period plus the stop time.
  localparam int STALL_CYC = (K_HALF_NS + STALL_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int RD_FIRST_DLL = 3;
  localparam int RD_FIRST_NODLL = 2;
  localparam int WR_FIRST = 2;
  localparam int STRAP_WAIT = 3;
  localparam logic [2:0] STEP_LAST = 3'h6;
  // ----------------------------------------------------------------
  // Controller timing
  // ----------------------------------------------------------------
  localparam int K_HALF_CYC = K_HALF_NS / SYS_PERIOD_NS;
  localparam logic [2:0] HS_RELEASE = 3'h2;
  localparam logic [2:0] HS_WR_DONE = 3'h6;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE = 3'b001,
    OP_READ = 3'b010,
    OP_WRITE = 3'b100
  } ddrs_op_type;

  typedef enum logic [2:0] {
    CS_IDLE = 3'b001,
    CS_WRITE = 3'b010,
    CS_READ = 3'b100
  } ddrs_ctl_state_type;
endpackage : ddrs_pkg

// [verilog/ddrs_link_if.sv]
`timescale 1ns/1ps
interface ddrs_link_if #(
  parameter int DATA_W = ddrs_pkg::DATA_W,
  parameter int LANES = ddrs_pkg::LANES,
  parameter int ADDR_W = ddrs_pkg::ADDR_W
);
  logic k;
  logic k_n;
  logic c;
  logic c_n;
  logic [ADDR_W-1:0] addr;
  logic read_port_select_n;
  logic write_port_select_n;
  logic [LANES-1:0] byte_lane_enable_n;
  logic [DATA_W-1:0] d;
  logic [DATA_W-1:0] q;
  logic q_oe;
  logic returned_timing_strobe;
  logic returned_timing_strobe_n;
  logic delay_loop_disable_n;

  modport dev (
    input k, k_n, c, c_n, addr, read_port_select_n, write_port_select_n,
    input byte_lane_enable_n, d, delay_loop_disable_n,
    output q, q_oe, returned_timing_strobe, returned_timing_strobe_n
  );
  modport ctl (
    output k, k_n, c, c_n, addr, read_port_select_n, write_port_select_n,
    output byte_lane_enable_n, d, delay_loop_disable_n,
    input q, q_oe, returned_timing_strobe, returned_timing_strobe_n
  );
endinterface : ddrs_link_if

// [verilog/ddrs_device.sv]
`timescale 1ns/1ps
// Every pin is sampled by clk_sys through two flops; clock pins are edge
// detected on the synchronised copy, so data and edges stay aligned.
// The nibble organisation is the same logic with LANE_W = 4.
module ddrs_device #(
  parameter int DATA_W = ddrs_pkg::DATA_W,
  parameter int LANE_W = ddrs_pkg::LANE_W,
  parameter int ADDR_W = ddrs_pkg::ADDR_W,
  parameter int STALL_CYC = ddrs_pkg::STALL_CYC,
  parameter int LOCK_CYCLES = ddrs_pkg::LOCK_CYCLES,
  parameter int CAL_INTERVAL = ddrs_pkg::CAL_INTERVAL
) (
  input wire logic clk_sys,
  input wire logic rst,
  ddrs_link_if.dev link,
  output logic dll_locked,
  output logic impedance_update,
  output logic single_clock_mode
);
  import ddrs_pkg::*;
  localparam int LANES = DATA_W / LANE_W;
  localparam int PW = 7 + LANES + ADDR_W + DATA_W;
  localparam int DEPTH = 2 ** ADDR_W;
  localparam int GW = $clog2(STALL_CYC + 1);
  localparam int LW = $clog2(LOCK_CYCLES);
  localparam int CW = $clog2(CAL_INTERVAL);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] pin_meta;
  logic [PW-1:0] pin_sync;
  logic [3:0] clk_prev;
  logic k_s, kn_s, c_s, cn_s, rps_n_s, wps_n_s, dll_on;
  logic [LANES-1:0] lane_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] d_s;

  assign pin_raw = {link.k, link.k_n, link.c, link.c_n, link.read_port_select_n,
                    link.write_port_select_n, link.delay_loop_disable_n,
                    link.byte_lane_enable_n, link.addr, link.d};
  assign {k_s, kn_s, c_s, cn_s, rps_n_s, wps_n_s, dll_on, lane_n_s, addr_s, d_s} = pin_sync;

  // Resetting to ones keeps both ports deselected and fakes no clock edge.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_meta <= '1;
      pin_sync <= '1;
      clk_prev <= '1;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      clk_prev <= pin_sync[PW-1 -: 4];
    end
  end

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  logic k_rise, kn_rise, out_rise, outn_rise, in_edge, out_edge;
  assign k_rise = k_s & ~clk_prev[3];
  assign kn_rise = kn_s & ~clk_prev[2];
  assign out_rise = single_clock_mode ? k_rise : (c_s & ~clk_prev[1]);
  assign outn_rise = single_clock_mode ? kn_rise : (cn_s & ~clk_prev[0]);
  assign in_edge = k_rise | kn_rise;
  assign out_edge = out_rise | outn_rise;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] next_mem [DEPTH];
  ddrs_op_type last_op, next_last_op;
  logic [1:0] rd_act, next_rd_act, wr_act, next_wr_act;
  logic [2:0] rd_step [2];
  logic [2:0] next_rd_step [2];
  logic [2:0] wr_step [2];
  logic [2:0] next_wr_step [2];
  logic [ADDR_W-1:0] rd_addr [2];
  logic [ADDR_W-1:0] next_rd_addr [2];
  logic [ADDR_W-1:0] wr_addr [2];
  logic [ADDR_W-1:0] next_wr_addr [2];
  logic [DATA_W-1:0] q, next_q;
  logic q_oe, next_q_oe, echo, next_echo, echo_n, next_echo_n;
  logic [GW-1:0] gap, next_gap;
  logic [LW-1:0] lock_cnt, next_lock_cnt;
  logic next_locked;
  logic [CW-1:0] cal_cnt, next_cal_cnt;
  logic next_cal;
  logic [1:0] strap_cnt, next_strap_cnt;
  logic next_single;

  always_comb begin
    logic r_req;
    logic w_req;
    logic any_beat;
    logic [2:0] step;
    logic [2:0] first;
    logic [ADDR_W-1:0] idx;
    r_req = 1'b0;
    w_req = 1'b0;
    any_beat = 1'b0;
    step = '0;
    first = dll_on ? 3'(RD_FIRST_DLL) : 3'(RD_FIRST_NODLL);
    idx = '0;
    next_mem = mem;
    next_last_op = last_op;
    next_rd_act = rd_act;
    next_wr_act = wr_act;
    next_rd_step = rd_step;
    next_wr_step = wr_step;
    next_rd_addr = rd_addr;
    next_wr_addr = wr_addr;
    next_q = q;
    next_q_oe = q_oe;
    next_gap = gap;
    next_lock_cnt = lock_cnt;
    next_locked = dll_locked;
    next_cal_cnt = cal_cnt;
    next_cal = 1'b0;
    next_strap_cnt = strap_cnt;
    next_single = single_clock_mode;

    // The strap is caught once the synchronisers hold real pin levels.
    if (strap_cnt != 2'(STRAP_WAIT)) begin
      next_strap_cnt = strap_cnt + 2'h1;
      if (strap_cnt == 2'(STRAP_WAIT - 1)) begin
        next_single = c_s & cn_s;
      end
    end

    // Echo clocks copy the launching clock levels every cycle.
    next_echo = single_clock_mode ? k_s : c_s;
    next_echo_n = single_clock_mode ? kn_s : cn_s;

    if (in_edge) begin
      next_gap = '0;
    end else if (gap != GW'(STALL_CYC)) begin
      next_gap = gap + GW'(1);
    end
    // A reset of the loop restarts the full lock count.
    if (!dll_on || gap == GW'(STALL_CYC)) begin
      next_lock_cnt = '0;
      next_locked = 1'b0;
    end else if (k_rise && !dll_locked) begin
      if (lock_cnt == LW'(LOCK_CYCLES - 1)) begin
        next_locked = 1'b1;
      end else begin
        next_lock_cnt = lock_cnt + LW'(1);
      end
    end

    // Without a clock edge nothing below moves, so a stopped clock holds.
    if (k_rise) begin
      if (cal_cnt == CW'(CAL_INTERVAL - 1)) begin
        next_cal_cnt = '0;
        next_cal = 1'b1;
      end else begin
        next_cal_cnt = cal_cnt + CW'(1);
      end
    end

    // Write beats land in the array lane by lane on both input phases.
    if (in_edge) begin
      for (int s = 0; s < 2; s++) begin
        if (wr_act[s]) begin
          step = wr_step[s] + 3'h1;
          next_wr_step[s] = step;
          if (step >= 3'(WR_FIRST)) begin
            idx = wr_addr[s] + ADDR_W'(step - 3'(WR_FIRST));
            for (int l = 0; l < LANES; l++) begin
              if (!lane_n_s[l]) begin
                next_mem[idx][l*LANE_W +: LANE_W] = d_s[l*LANE_W +: LANE_W];
              end
            end
          end
          if (step == 3'(WR_FIRST + BURST - 1)) begin
            next_wr_act[s] = 1'b0;
          end
        end
      end
    end

    // Read words launch on output clock edges; the output register holds
    // between them and drops its enable after the last word.
    if (out_edge) begin
      for (int s = 0; s < 2; s++) begin
        if (rd_act[s]) begin
          step = rd_step[s] + 3'h1;
          next_rd_step[s] = step;
          if (step >= first && step < first + 3'(BURST)) begin
            next_q = mem[rd_addr[s] + ADDR_W'(step - first)];
            any_beat = 1'b1;
          end
          if (step == first + 3'(BURST - 1)) begin
            next_rd_act[s] = 1'b0;
          end
        end
      end
      next_q_oe = any_beat;
    end

    // One operation per rise; the port that ran last yields.
    if (k_rise) begin
      r_req = !rps_n_s && last_op != OP_READ;
      w_req = !wps_n_s && last_op != OP_WRITE;
      if (r_req) begin
        next_last_op = OP_READ;
        if (!rd_act[0]) begin
          next_rd_act[0] = 1'b1;
          next_rd_step[0] = '0;
          next_rd_addr[0] = addr_s;
        end else begin
          next_rd_act[1] = 1'b1;
          next_rd_step[1] = '0;
          next_rd_addr[1] = addr_s;
        end
      end else if (w_req) begin
        next_last_op = OP_WRITE;
        if (!wr_act[0]) begin
          next_wr_act[0] = 1'b1;
          next_wr_step[0] = '0;
          next_wr_addr[0] = addr_s;
        end else begin
          next_wr_act[1] = 1'b1;
          next_wr_step[1] = '0;
          next_wr_addr[1] = addr_s;
        end
      end else begin
        next_last_op = OP_NONE;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    mem <= next_mem;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      last_op <= OP_NONE;
      rd_act <= '0;
      wr_act <= '0;
      rd_step <= '{default: '0};
      wr_step <= '{default: '0};
      rd_addr <= '{default: '0};
      wr_addr <= '{default: '0};
      q <= '0;
      q_oe <= 1'b0;
      echo <= 1'b0;
      echo_n <= 1'b0;
      gap <= '0;
      lock_cnt <= '0;
      dll_locked <= 1'b0;
      cal_cnt <= '0;
      impedance_update <= 1'b0;
      strap_cnt <= '0;
      single_clock_mode <= 1'b0;
    end else begin
      last_op <= next_last_op;
      rd_act <= next_rd_act;
      wr_act <= next_wr_act;
      rd_step <= next_rd_step;
      wr_step <= next_wr_step;
      rd_addr <= next_rd_addr;
      wr_addr <= next_wr_addr;
      q <= next_q;
      q_oe <= next_q_oe;
      echo <= next_echo;
      echo_n <= next_echo_n;
      gap <= next_gap;
      lock_cnt <= next_lock_cnt;
      dll_locked <= next_locked;
      cal_cnt <= next_cal_cnt;
      impedance_update <= next_cal;
      strap_cnt <= next_strap_cnt;
      single_clock_mode <= next_single;
    end
  end

  assign link.q = q;
  assign link.q_oe = q_oe;
  assign link.returned_timing_strobe = echo;
  assign link.returned_timing_strobe_n = echo_n;
endmodule : ddrs_device

// [verilog/ddrs_controller.sv]
`timescale 1ns/1ps
module ddrs_controller #(
  parameter int DATA_W = ddrs_pkg::DATA_W,
  parameter int LANE_W = ddrs_pkg::LANE_W,
  parameter int ADDR_W = ddrs_pkg::ADDR_W,
  parameter int K_HALF_CYC = ddrs_pkg::K_HALF_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  ddrs_link_if.ctl link,
  input wire logic dll_enable,
  input wire logic single_clock_strap,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [ddrs_pkg::BURST*DATA_W-1:0] cmd_wdata,
  input wire logic [ddrs_pkg::BURST*(DATA_W/LANE_W)-1:0] cmd_lane_n,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [ddrs_pkg::BURST*DATA_W-1:0] rsp_data
);
  import ddrs_pkg::*;
  localparam int LANES = DATA_W / LANE_W;
  localparam int DW = $clog2(K_HALF_CYC + 1);
  localparam int SW = DATA_W + 3;

  // ----------------------------------------------------------------
  // Link clock divider and return-path synchronisers
  // ----------------------------------------------------------------
  logic [DW-1:0] div_cnt;
  logic k_lvl;
  logic tick;
  logic mid;
  logic [SW-1:0] ret_meta, ret_sync;
  logic [1:0] echo_prev;
  logic echo_edge;

  assign tick = div_cnt == DW'(K_HALF_CYC - 1);
  assign mid = div_cnt == DW'(K_HALF_CYC / 2 - 1);
  assign echo_edge = (ret_sync[SW-2] & ~echo_prev[1]) | (ret_sync[SW-3] & ~echo_prev[0]);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_cnt <= '0;
      k_lvl <= 1'b0;
      ret_meta <= '0;
      ret_sync <= '0;
      echo_prev <= '0;
    end else begin
      div_cnt <= tick ? '0 : div_cnt + DW'(1);
      k_lvl <= k_lvl ^ tick;
      ret_meta <= {link.q_oe, link.returned_timing_strobe, link.returned_timing_strobe_n, link.q};
      ret_sync <= ret_meta;
      echo_prev <= ret_sync[SW-2 -: 2];
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  ddrs_ctl_state_type state, next_state;
  logic [2:0] hstep, next_hstep;
  logic [ADDR_W-1:0] addr, next_addr;
  logic rps_n, next_rps_n, wps_n, next_wps_n;
  logic [BURST*DATA_W-1:0] wbuf, next_wbuf, rbuf, next_rbuf;
  logic [BURST*LANES-1:0] lbuf, next_lbuf;
  logic [DATA_W-1:0] d, next_d;
  logic [LANES-1:0] lane_n, next_lane_n;
  logic [1:0] words, next_words;
  logic [BURST*DATA_W-1:0] fifo [2];
  logic [BURST*DATA_W-1:0] next_fifo [2];
  logic wptr, next_wptr, rptr, next_rptr;
  logic [1:0] count, next_count;

  // A read is issued only when its whole burst has a free slot, so a
  // stalled consumer holds off the link instead of losing words.
  assign cmd_ready = state == CS_IDLE && tick && k_lvl && (cmd_write || count != FIFO_DEPTH);
  assign rsp_valid = count != 2'h0;
  assign rsp_data = fifo[rptr];

  always_comb begin
    logic push;
    logic pop;
    push = 1'b0;
    pop = rsp_valid && rsp_ready;
    next_state = state;
    next_hstep = hstep;
    next_addr = addr;
    next_rps_n = rps_n;
    next_wps_n = wps_n;
    next_wbuf = wbuf;
    next_lbuf = lbuf;
    next_rbuf = rbuf;
    next_d = d;
    next_lane_n = lane_n;
    next_words = words;
    next_fifo = fifo;
    next_wptr = wptr;
    next_rptr = rptr;
    unique case (state)
      CS_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          next_addr = cmd_addr;
          next_hstep = '0;
          next_words = '0;
          next_wbuf = cmd_wdata;
          next_lbuf = cmd_lane_n;
          next_rps_n = cmd_write;
          next_wps_n = !cmd_write;
          next_state = cmd_write ? CS_WRITE : CS_READ;
        end
      end
      CS_WRITE: begin
        if (tick) begin
          next_hstep = hstep + 3'h1;
          if (hstep + 3'h1 == HS_RELEASE) begin
            next_wps_n = 1'b1;
          end
          if (hstep + 3'h1 == HS_WR_DONE) begin
            next_state = CS_IDLE;
          end
        end
        // Beats move midway between link edges; a beat that moved on the
        // taking edge would reach the device together with that edge.
        if (mid && hstep >= HS_RELEASE && hstep < HS_WR_DONE) begin
          next_d = wbuf[DATA_W-1:0];
          next_lane_n = lbuf[LANES-1:0];
          next_wbuf = wbuf >> DATA_W;
          next_lbuf = lbuf >> LANES;
        end
      end
      CS_READ: begin
        if (tick && hstep != HS_RELEASE) begin
          next_hstep = hstep + 3'h1;
          if (hstep + 3'h1 == HS_RELEASE) begin
            next_rps_n = 1'b1;
          end
        end
        // Words are caught on echo edges, so latency mode does not matter.
        if (echo_edge && ret_sync[SW-1]) begin
          next_rbuf[words*DATA_W +: DATA_W] = ret_sync[DATA_W-1:0];
          next_words = words + 2'h1;
          if (words == 2'(BURST - 1)) begin
            push = 1'b1;
            next_fifo[wptr] = next_rbuf;
            next_wptr = !wptr;
            next_state = CS_IDLE;
          end
        end
      end
    endcase
    if (pop) begin
      next_rptr = !rptr;
    end
    next_count = count + 2'(push) - 2'(pop);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= CS_IDLE;
      hstep <= '0;
      addr <= '0;
      rps_n <= 1'b1;
      wps_n <= 1'b1;
      wbuf <= '0;
      lbuf <= '1;
      rbuf <= '0;
      d <= '0;
      lane_n <= '1;
      words <= '0;
      fifo <= '{default: '0};
      wptr <= 1'b0;
      rptr <= 1'b0;
      count <= '0;
    end else begin
      state <= next_state;
      hstep <= next_hstep;
      addr <= next_addr;
      rps_n <= next_rps_n;
      wps_n <= next_wps_n;
      wbuf <= next_wbuf;
      lbuf <= next_lbuf;
      rbuf <= next_rbuf;
      d <= next_d;
      lane_n <= next_lane_n;
      words <= next_words;
      fifo <= next_fifo;
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
    end
  end

  // Output clocks park high in single-clock mode, which is the strap.
  assign link.k = k_lvl;
  assign link.k_n = ~k_lvl;
  assign link.c = single_clock_strap | k_lvl;
  assign link.c_n = single_clock_strap | ~k_lvl;
  assign link.addr = addr;
  assign link.read_port_select_n = rps_n;
  assign link.write_port_select_n = wps_n;
  assign link.byte_lane_enable_n = lane_n;
  assign link.d = d;
  assign link.delay_loop_disable_n = dll_enable;
endmodule : ddrs_controller

// [verification/ddrs_link_monitor.sv]
`timescale 1ns/1ps
module ddrs_link_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic k,
  input wire logic [ddrs_pkg::ADDR_W-1:0] addr,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic q_oe,
  input wire logic returned_timing_strobe,
  input wire logic returned_timing_strobe_n
);
  import ddrs_pkg::*;
  logic [3:0] up;
  logic [6:0] rd_idle;
  logic [3:0] next_up;
  logic [6:0] next_rd_idle;
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  // Echo checks wait until the pin synchronisers have flushed their reset ones.
  always_comb begin
    next_up = (up == 4'hf) ? up : up + 4'h1;
    next_rd_idle = (rd_idle == 7'h7f) ? rd_idle : rd_idle + 7'h01;
    if (!read_port_select_n) begin
      next_rd_idle = 7'h00;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      up <= 4'h0;
      rd_idle <= 7'h00;
    end else begin
      up <= next_up;
      rd_idle <= next_rd_idle;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Link checks
  // ----------------------------------------------------------------
  echo_period_a: assert property (
    up == 4'hf && $rose(returned_timing_strobe) |=>
    returned_timing_strobe[*5] ##1 !returned_timing_strobe) else $error("echo high time wrong");
  echo_compl_a: assert property (
    up == 4'hf && $fell(returned_timing_strobe) |-> ##[0:1] returned_timing_strobe_n)
    else $error("echo pair not complementary");
  oe_on_edge_a: assert property (
    $changed(q_oe) |-> $changed(returned_timing_strobe) || $changed(returned_timing_strobe_n))
    else $error("read enable moved off an output edge");
  nop_quiet_a: assert property (
    rd_idle >= 7'h3c |-> !q_oe) else $error("read data without a read");
  rsel_release_a: assert property (
    $fell(read_port_select_n) |-> ##[1:14] read_port_select_n)
    else $error("read select held too long");
  wsel_release_a: assert property (
    $fell(write_port_select_n) |-> ##[1:14] write_port_select_n)
    else $error("write select held too long");
  addr_hold_a: assert property (
    (!read_port_select_n && !$fell(read_port_select_n)) ||
    (!write_port_select_n && !$fell(write_port_select_n)) |-> $stable(addr))
    else $error("address moved while selected");
  k_steady_a: assert property (
    $rose(k) |=> k[*5] ##1 !k) else $error("link clock period not steady");
  burst_span_a: assert property (
    $rose(q_oe) |-> q_oe[*8] ##[14:18] !q_oe) else $error("read burst length wrong");
endmodule : ddrs_link_monitor

// [verification/ddr_burst_sram_port_tb.sv]
`timescale 1ns/1ps
module ddr_burst_sram_port_tb;
  import ddrs_pkg::*;
  logic clk_sys = 0, rst = 1, dll_enable = 1, cmd_valid = 0, cmd_write = 0, rsp_ready = 0;
  logic strap = 0;
  logic cmd_ready, rsp_valid, dll_locked, impedance_update, single_clock_mode;
  logic [ADDR_W-1:0] cmd_addr = '0;
  logic [BURST*DATA_W-1:0] cmd_wdata = '0, rsp_data;
  logic [BURST*LANES-1:0] cmd_lane_n = '1;
  logic [DATA_W-1:0] mem [16];
  logic [BURST*DATA_W-1:0] expq [$];
  int miscompares = 0, total_checks = 0, cycles = 0;
  integer seed = 32'hca7e99c1;
  always #5 clk_sys = ~clk_sys;
  ddrs_link_if ddrs_link_if_i ();
  ddrs_device #(.LOCK_CYCLES(8), .CAL_INTERVAL(8)) ddrs_device_i (.clk_sys(clk_sys), .rst(rst),
    .link(ddrs_link_if_i.dev), .dll_locked(dll_locked), .impedance_update(impedance_update),
    .single_clock_mode(single_clock_mode));
  ddrs_controller ddrs_controller_i (.clk_sys(clk_sys), .rst(rst), .link(ddrs_link_if_i.ctl),
    .dll_enable(dll_enable), .single_clock_strap(strap), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_lane_n(cmd_lane_n), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data));
  ddrs_link_monitor ddrs_link_monitor_i (.clk_sys(clk_sys), .rst(rst), .k(ddrs_link_if_i.k),
    .addr(ddrs_link_if_i.addr), .read_port_select_n(ddrs_link_if_i.read_port_select_n),
    .write_port_select_n(ddrs_link_if_i.write_port_select_n), .q_oe(ddrs_link_if_i.q_oe),
    .returned_timing_strobe(ddrs_link_if_i.returned_timing_strobe),
    .returned_timing_strobe_n(ddrs_link_if_i.returned_timing_strobe_n));
  // ----------------------------------------------------------------
  // Compare and closing tasks
  // ----------------------------------------------------------------
  task chk_word(input logic [BURST*DATA_W-1:0] e, input logic [BURST*DATA_W-1:0] s);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR rsp_data expected %h seen %h", e, s);
    end
  endtask : chk_word
  task chk_val(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk_val
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // ----------------------------------------------------------------
  // Command driver with reference memory
  // ----------------------------------------------------------------
  // Notes the expected burst at issue; commands are serial, so the model stays in step.
  task op(input logic wr, input logic [ADDR_W-1:0] a, input logic [BURST*LANES-1:0] ln);
    int n;
    logic [95:0] r;
    logic [BURST*DATA_W-1:0] e;
    r = {$random(seed), $random(seed), $random(seed)};
    for (int i = 0; i < BURST; i++) begin
      for (int j = 0; j < LANES; j++) begin
        if (wr && !ln[i*LANES+j]) begin
          mem[4'(a + 4'(i))][j*LANE_W +: LANE_W] = r[i*DATA_W+j*LANE_W +: LANE_W];
        end
      end
      e[i*DATA_W +: DATA_W] = mem[4'(a + 4'(i))];
    end
    if (!wr) begin
      expq.push_back(e);
    end
    @(posedge clk_sys);
    #1;
    cmd_valid = 1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_wdata = r[BURST*DATA_W-1:0];
    cmd_lane_n = ln;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    @(posedge clk_sys);
    #1;
    cmd_valid = 0;
  endtask : op
  task run_ops(input int cnt);
    logic [31:0] r;
    for (int i = 0; i < cnt; i++) begin
      r = $random(seed);
      op(r[0], r[7:4], r[15:8]);
    end
    for (int i = 0; i < 2000 && expq.size() > 0; i++) begin
      @(posedge clk_sys);
    end
    chk_val("pending", 0, expq.size());
  endtask : run_ops
  // ----------------------------------------------------------------
  // Response watcher, stalling receiver and timeout
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    #1 rsp_ready = ($random(seed) & 3) != 0;
  end
  always @(negedge clk_sys) begin
    if (!rst && rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
      if (expq.size() == 0) begin
        miscompares++;
        $display("ERROR rsp_data expected none seen %h", rsp_data);
      end else begin
        chk_word(expq.pop_front(), rsp_data);
      end
    end
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    repeat (16) @(posedge clk_sys);
    #1 rst = 0;
    for (int a = 0; a < 16; a += 4) begin
      op(1'b1, 4'(a), 8'h00);
    end
    run_ops(30);
    n = 0;
    while (impedance_update !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (impedance_update !== 1'b1 && n < 400);
    chk_val("impedance_gap", 96, n);
    chk_val("dll_locked", 1, dll_locked);
    chk_val("single_clock", 0, single_clock_mode);
    rst = 1;
    dll_enable = 0;
    repeat (16) @(posedge clk_sys);
    #1 rst = 0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk_val("dll_relock", 0, dll_locked);
    run_ops(16);
    // A last write must drain before the strap reset cuts it off.
    repeat (64) @(posedge clk_sys);
    #1 rst = 1;
    strap = 1;
    dll_enable = 1;
    repeat (16) @(posedge clk_sys);
    #1 rst = 0;
    run_ops(8);
    @(posedge clk_sys);
    #1;
    chk_val("single_clock_on", 1, single_clock_mode);
    chk_val("dll_locked_again", 1, dll_locked);
    report_and_stop();
  end
endmodule : ddr_burst_sram_port_tb
